// ---- rrtf_buffer.sv ----
// Package of shared constants and the byte buffer used for both directions.
// Assumes a single clock domain on mclk_i and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Shared constants
// ==========================================================================
package rrtf_pkg;
	localparam int BUF_DEPTH = 64;
	localparam int BYTE_W = 8;
	localparam int COUNT_W = 7;
	localparam int THR_W = 4;
	localparam int SEL_W = 6;
	localparam int PIN_COUNT = 3;
	// Serial header layout
	localparam int HDR_RW_BIT = 7;
	localparam int HDR_BURST_BIT = 6;
	localparam logic [5:0] FIFO_ADDR = 6'h3f;
	// Threshold coding
	localparam logic [6:0] RX_THR_STEP = 7'h04;
	localparam logic [6:0] TX_THR_BASE = 7'h3d;
	localparam logic [6:0] STATUS_CNT_MAX = 7'h0f;
	// Output pin selection codes
	localparam logic [5:0] SEL_RX_THR = 6'h00;
	localparam logic [5:0] SEL_TX_THR = 6'h02;
	localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : rrtf_pkg

// ==========================================================================
// Byte buffer with valid and ready on both sides
// ==========================================================================
module rrtf_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	parameter bit DUP_ON_LAST = 1'b0
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic flush_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i,
	// Status
	output logic [$clog2(DEPTH+1)-1:0] count_o,
	output logic overflow_o,
	output logic underflow_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	// Elaboration check on depth
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("rrtf_buffer: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic full;
	logic empty;
	logic push;
	logic pop_req;
	logic hazard;
	logic pop;

	// Handshake decode
	assign full = (count_reg == CW'(DEPTH));
	assign empty = (count_reg == '0);
	assign push = in_valid_i && !full;
	assign pop_req = out_ready_i && !empty;
	assign hazard = DUP_ON_LAST && pop_req && push && (count_reg == CW'(1));
	assign pop = pop_req && !hazard;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign count_o = count_reg;
	assign overflow_o = in_valid_i && full;
	assign underflow_o = out_ready_i && empty;

	// Storage, written in arrival order
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge mclk_i) begin
		if (srst_i || flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end
endmodule : rrtf_buffer

`default_nettype wire

// ---- rrtf_top.sv ----
// Receive and transmit byte buffers of the radio, with the serial host port.
// Assumes the radio datapath runs on mclk_i and the host serial pins are
// asynchronous; they are synchronised here and their clock edges detected.
//
// Notes on behaviour
// - Two separate 64-byte buffers exist, one for received and one for outgoing bytes.
// - The host only reads the receive buffer and only writes the transmit buffer over serial.
// - Receive overflow and transmit underflow are detected and flagged.
// - During the header byte a status byte is shifted out holding the relevant fill level capped at 15.
// - Both buffer byte counts are visible as read-only status at all times.
// - A radio write coinciding with the host reading the last byte repeats that byte.
// - Setting v gives a receive threshold of 4*(v+1) and a transmit threshold of 61-4*v.
// - A threshold flag is high while the count is at or above its threshold.
// - Select code 0x00 shows the receive flag and 0x02 the transmit flag on a pin.
`timescale 1ns/1ps
`default_nettype none

module rrtf_top #(
	parameter int DEPTH = rrtf_pkg::BUF_DEPTH
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Host serial pins
	input wire logic spi_csn_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	// Radio receive side
	input wire logic rx_data_valid_i,
	input wire logic [rrtf_pkg::BYTE_W-1:0] rx_data_i,
	output logic rx_data_ready_o,
	// Radio transmit side
	output logic tx_data_valid_o,
	output logic [rrtf_pkg::BYTE_W-1:0] tx_data_o,
	input wire logic tx_data_ready_i,
	// Control
	input wire logic rx_flush_i,
	input wire logic tx_flush_i,
	input wire logic [rrtf_pkg::THR_W-1:0] buffer_threshold_select_i,
	input wire logic [rrtf_pkg::PIN_COUNT*rrtf_pkg::SEL_W-1:0] output_pin_signal_select_i,
	// Status
	output logic [rrtf_pkg::COUNT_W-1:0] rx_buffer_count_o,
	output logic [rrtf_pkg::COUNT_W-1:0] tx_buffer_count_o,
	output logic rx_overflow_o,
	output logic tx_underflow_o,
	output logic rx_threshold_o,
	output logic tx_threshold_o,
	output logic [rrtf_pkg::PIN_COUNT-1:0] general_output_pin_o
);
	localparam int BW = rrtf_pkg::BYTE_W;
	localparam int CW = rrtf_pkg::COUNT_W;

	// Elaboration check on depth
	generate
		if (DEPTH != rrtf_pkg::BUF_DEPTH) begin : g_bad_depth
			$error("rrtf_top: threshold coding needs DEPTH of 64");
		end
	endgenerate

	// Status nibble of a fill count, saturated at fifteen
	function automatic logic [BW-1:0] status_of(input logic [CW-1:0] cnt);
		logic [CW-1:0] sat;
		sat = (cnt > rrtf_pkg::STATUS_CNT_MAX) ? rrtf_pkg::STATUS_CNT_MAX : cnt;
		status_of = {4'h0, sat[3:0]};
	endfunction : status_of

	// ======================================================================
	// Pin synchronisers and edge detection
	// ======================================================================
	logic [1:0] csn_sync_reg;
	logic [1:0] sclk_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic sclk_prev_reg;
	logic csn_prev_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic csn_fall;

	// Two flops per pin, second stage only is read
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			csn_sync_reg <= 2'h3;
			sclk_sync_reg <= 2'h0;
			mosi_sync_reg <= 2'h0;
		end else begin
			csn_sync_reg <= {csn_sync_reg[0], spi_csn_i};
			sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk_i};
			mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_i};
		end
	end

	// Previous levels for edge finding
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sclk_prev_reg <= 1'b0;
			csn_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_sync_reg[1];
			csn_prev_reg <= csn_sync_reg[1];
		end
	end

	assign sclk_rise = !csn_sync_reg[1] && sclk_sync_reg[1] && !sclk_prev_reg;
	assign sclk_fall = !csn_sync_reg[1] && !sclk_sync_reg[1] && sclk_prev_reg;
	assign csn_fall = !csn_sync_reg[1] && csn_prev_reg;

	// ======================================================================
	// Buffers
	// ======================================================================
	logic rx_pop;
	logic [BW-1:0] rx_head;
	logic rx_ovf_pulse;
	logic tx_push;
	logic [BW-1:0] tx_byte;
	logic tx_unf_pulse;

	// Receive buffer, filled by the radio, drained by the host
	rrtf_buffer #(.WIDTH(BW), .DEPTH(DEPTH), .DUP_ON_LAST(1'b1)) u_rx_buf (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.flush_i(rx_flush_i),
		.in_valid_i(rx_data_valid_i),
		.in_data_i(rx_data_i),
		.in_ready_o(rx_data_ready_o),
		.out_valid_o(),
		.out_data_o(rx_head),
		.out_ready_i(rx_pop),
		.count_o(rx_buffer_count_o),
		.overflow_o(rx_ovf_pulse),
		.underflow_o()
	);

	// Transmit buffer, filled by the host, drained by the radio
	rrtf_buffer #(.WIDTH(BW), .DEPTH(DEPTH), .DUP_ON_LAST(1'b0)) u_tx_buf (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.flush_i(tx_flush_i),
		.in_valid_i(tx_push),
		.in_data_i(tx_byte),
		.in_ready_o(),
		.out_valid_o(tx_data_valid_o),
		.out_data_o(tx_data_o),
		.out_ready_i(tx_data_ready_i),
		.count_o(tx_buffer_count_o),
		.overflow_o(),
		.underflow_o(tx_unf_pulse)
	);

	// Sticky error flags, an event beats a flush in the same cycle
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rx_overflow_o <= 1'b0;
			tx_underflow_o <= 1'b0;
		end else begin
			rx_overflow_o <= rx_ovf_pulse || (rx_overflow_o && !rx_flush_i);
			tx_underflow_o <= tx_unf_pulse || (tx_underflow_o && !tx_flush_i);
		end
	end

	// ======================================================================
	// Serial host port
	// ======================================================================
	logic [2:0] bit_cnt_reg;
	logic [BW-1:0] shift_in_reg;
	logic [BW-1:0] out_byte_reg;
	logic in_header_reg;
	logic hdr_read_reg;
	logic hdr_burst_reg;
	logic hdr_fifo_reg;
	logic byte_done;
	logic [BW-1:0] rx_byte;
	logic hdr_read_now;
	logic rx_peek;
	logic fifo_now;
	logic data_phase_ok;

	assign rx_byte = {shift_in_reg[BW-2:0], mosi_sync_reg[1]};
	assign byte_done = sclk_rise && (bit_cnt_reg == rrtf_pkg::LAST_BIT);
	assign hdr_read_now = in_header_reg ? rx_byte[rrtf_pkg::HDR_RW_BIT] : hdr_read_reg;
	assign fifo_now = in_header_reg ? (rx_byte[5:0] == rrtf_pkg::FIFO_ADDR) : hdr_fifo_reg;
	assign data_phase_ok = in_header_reg || hdr_burst_reg;
	// Host reads only the receive side and writes only the transmit side
	// Head is copied when a data byte is due, popped only once the host clocks it
	assign rx_peek = byte_done && fifo_now && hdr_read_now && data_phase_ok;
	assign rx_pop = sclk_rise && (bit_cnt_reg == 3'h0) && !in_header_reg && hdr_fifo_reg
		&& hdr_read_reg;
	assign tx_push = byte_done && !in_header_reg && hdr_fifo_reg && !hdr_read_reg;
	assign tx_byte = rx_byte;

	// Bit counter and input shifter
	always_ff @(posedge mclk_i) begin
		if (srst_i || csn_fall) begin
			bit_cnt_reg <= 3'h0;
			shift_in_reg <= '0;
		end else if (sclk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_in_reg <= rx_byte;
		end
	end

	// Header capture
	always_ff @(posedge mclk_i) begin
		if (srst_i || csn_fall) begin
			in_header_reg <= 1'b1;
			hdr_read_reg <= 1'b0;
			hdr_burst_reg <= 1'b0;
			hdr_fifo_reg <= 1'b0;
		end else if (byte_done && in_header_reg) begin
			in_header_reg <= 1'b0;
			hdr_read_reg <= rx_byte[rrtf_pkg::HDR_RW_BIT];
			hdr_burst_reg <= rx_byte[rrtf_pkg::HDR_BURST_BIT];
			hdr_fifo_reg <= (rx_byte[5:0] == rrtf_pkg::FIFO_ADDR);
		end else if (byte_done && !hdr_burst_reg) begin
			hdr_fifo_reg <= 1'b0; // Single access ends after one byte
		end
	end

	// Outgoing byte: status during header, buffer head after it on FIFO reads, else zero
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			out_byte_reg <= '0;
		end else if (csn_fall) begin
			out_byte_reg <= status_of(rx_buffer_count_o);
		end else if (sclk_rise && in_header_reg && bit_cnt_reg == 3'h0) begin
			out_byte_reg <= mosi_sync_reg[1] ? status_of(rx_buffer_count_o)
				: status_of(tx_buffer_count_o);
		end else if (byte_done) begin
			out_byte_reg <= rx_peek ? rx_head : '0;
		end
	end

	// Output bit changes on falling clock edges
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			spi_miso_o <= 1'b0;
		end else if (csn_fall) begin
			spi_miso_o <= 1'b0;
		end else if (sclk_fall) begin
			spi_miso_o <= out_byte_reg[rrtf_pkg::LAST_BIT - bit_cnt_reg];
		end
	end

	assign spi_miso_oe_o = !csn_sync_reg[1];

	// ======================================================================
	// Thresholds and output pins
	// ======================================================================
	logic [CW-1:0] rx_thr;
	logic [CW-1:0] tx_thr;
	logic [CW-1:0] thr_ext;

	// Oppositely coded thresholds
	assign thr_ext = {3'h0, buffer_threshold_select_i};
	assign rx_thr = CW'((thr_ext + CW'(1)) * rrtf_pkg::RX_THR_STEP);
	assign tx_thr = CW'(rrtf_pkg::TX_THR_BASE - thr_ext * rrtf_pkg::RX_THR_STEP);

	// Registered threshold flags
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rx_threshold_o <= 1'b0;
			tx_threshold_o <= 1'b0;
		end else begin
			rx_threshold_o <= (rx_buffer_count_o >= rx_thr);
			tx_threshold_o <= (tx_buffer_count_o >= tx_thr);
		end
	end

	// Per-pin signal selection
	genvar gi;
	generate
		for (gi = 0; gi < rrtf_pkg::PIN_COUNT; gi++) begin : g_pin
			logic [rrtf_pkg::SEL_W-1:0] sel;
			assign sel = output_pin_signal_select_i[gi*rrtf_pkg::SEL_W +: rrtf_pkg::SEL_W];
			always_ff @(posedge mclk_i) begin
				if (srst_i) begin
					general_output_pin_o[gi] <= 1'b0;
				end else begin
					case (sel)
						rrtf_pkg::SEL_RX_THR: general_output_pin_o[gi] <= rx_threshold_o;
						rrtf_pkg::SEL_TX_THR: general_output_pin_o[gi] <= tx_threshold_o;
						default: general_output_pin_o[gi] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate
endmodule : rrtf_top

`default_nettype wire

// ---- rrtf_checker.sv ----
// Port checker for the radio buffer block.
// Assumes one clock domain and a bind onto rrtf_top.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker
// ==========================================
module rrtf_checker #(
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Inputs watched
	input wire logic spi_csn_i,
	input wire logic rx_data_valid_i,
	input wire logic tx_data_ready_i,
	input wire logic rx_flush_i,
	input wire logic tx_flush_i,
	input wire logic [3:0] buffer_threshold_select_i,
	input wire logic [17:0] output_pin_signal_select_i,
	// Outputs watched
	input wire logic rx_data_ready_o,
	input wire logic tx_data_valid_o,
	input wire logic [6:0] rx_buffer_count_o,
	input wire logic [6:0] tx_buffer_count_o,
	input wire logic rx_overflow_o,
	input wire logic tx_underflow_o,
	input wire logic rx_threshold_o,
	input wire logic tx_threshold_o,
	input wire logic [2:0] general_output_pin_o
);
	logic [2:0] idle_reg;
	wire logic idle = idle_reg == 3'h7;
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	// Cycles since chip select went high, no serial pops then
	always_ff @(posedge mclk_i) begin
		if (srst_i || !spi_csn_i) idle_reg <= 3'h0;
		else if (!idle) idle_reg <= idle_reg + 3'h1;
	end
	property p_rx_push;
		rx_data_valid_i && rx_data_ready_o && !rx_flush_i && idle
			|=> rx_buffer_count_o == $past(rx_buffer_count_o) + 7'h01;
	endproperty
	a_rx_push: assert property (p_rx_push) else $error("rx count missed a push");
	property p_tx_pop;
		tx_data_valid_o && tx_data_ready_i && !tx_flush_i && idle
			|=> tx_buffer_count_o == $past(tx_buffer_count_o) - 7'h01;
	endproperty
	a_tx_pop: assert property (p_tx_pop) else $error("tx count missed a pop");
	property p_rx_ready;
		1'b1 |-> rx_data_ready_o == (rx_buffer_count_o < DEPTH);
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("rx ready not full flag");
	property p_ovf;
		rx_data_valid_i && !rx_data_ready_o && !rx_flush_i |=> rx_overflow_o;
	endproperty
	a_ovf: assert property (p_ovf) else $error("rx overflow not flagged");
	property p_unf;
		tx_data_ready_i && !tx_data_valid_o && !tx_flush_i
			|=> tx_underflow_o ##1 (tx_underflow_o || $past(tx_flush_i));
	endproperty
	a_unf: assert property (p_unf) else $error("tx underflow not flagged");
	property p_rx_thr;
		1'b1 |=> rx_threshold_o
			== ($past(rx_buffer_count_o) >= 4 * ($past(buffer_threshold_select_i) + 1));
	endproperty
	a_rx_thr: assert property (p_rx_thr) else $error("rx threshold flag wrong");
	property p_tx_thr;
		1'b1 |=> tx_threshold_o
			== ($past(tx_buffer_count_o) >= 61 - 4 * $past(buffer_threshold_select_i));
	endproperty
	a_tx_thr: assert property (p_tx_thr) else $error("tx threshold flag wrong");
	property p_pin_rx;
		output_pin_signal_select_i[5:0] == 6'h00 |=> general_output_pin_o[0] == $past(rx_threshold_o);
	endproperty
	a_pin_rx: assert property (p_pin_rx) else $error("pin 0 not rx flag");
	property p_pin_tx;
		output_pin_signal_select_i[11:6] == 6'h02 |=> general_output_pin_o[1] == $past(tx_threshold_o);
	endproperty
	a_pin_tx: assert property (p_pin_tx) else $error("pin 1 not tx flag");
	// Main scenarios reached
	c_ovf: cover property ($rose(rx_overflow_o));
	c_unf: cover property ($rose(tx_underflow_o));
	c_pin: cover property ($fell(general_output_pin_o[1]));
endmodule : rrtf_checker
`default_nettype wire

// ---- rrtf_host_model.sv ----
// Host model driving the serial port, mode 0, MSB first.
// Assumes the bench resolves the device output into spi_miso_i.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host model
// ==========================================
module rrtf_host_model (
	// Serial pins
	output logic spi_csn_o,
	output logic spi_sclk_o,
	output logic spi_mosi_o,
	input wire logic spi_miso_i
);
	// Idle pins, clock still between frames
	initial begin
		spi_csn_o = 1'b1;
		spi_sclk_o = 1'b0;
		spi_mosi_o = 1'b0;
	end
	// Header and one data byte, reply sampled on each rising edge
	task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] st,
		output logic [7:0] rd);
		logic [15:0] sh;
		logic [15:0] rx;
		sh = {hdr, wd};
		spi_csn_o = 1'b0;
		#24;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi_o = sh[i];
			#24 spi_sclk_o = 1'b1;
			rx[i] = spi_miso_i;
			#24 spi_sclk_o = 1'b0;
		end
		spi_csn_o = 1'b1;
		#48;
		st = rx[15:8];
		rd = rx[7:0];
	endtask : xfer
endmodule : rrtf_host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the radio buffer block.
// Assumes checker and host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
// ==========================================
module testbench;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic spi_csn_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
	logic rx_data_valid_i = 1'b0;
	logic tx_data_ready_i = 1'b0;
	logic rx_flush_i = 1'b0;
	logic tx_flush_i = 1'b0;
	logic [7:0] rx_data_i = 8'h00;
	logic [3:0] buffer_threshold_select_i = 4'h0;
	logic [17:0] output_pin_signal_select_i = {6'h01, 6'h02, 6'h00};
	logic rx_data_ready_o, tx_data_valid_o, rx_overflow_o, tx_underflow_o;
	logic rx_threshold_o, tx_threshold_o;
	logic [7:0] tx_data_o;
	logic [6:0] rx_buffer_count_o, tx_buffer_count_o;
	logic [2:0] general_output_pin_o;
	wire logic miso_w = spi_miso_oe_o ? spi_miso_o : !spi_miso_o;
	int fails = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'hae783777;
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	rrtf_top #(.DEPTH(64)) rrtf_top_inst (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.spi_csn_i(spi_csn_i),
		.spi_sclk_i(spi_sclk_i),
		.spi_mosi_i(spi_mosi_i),
		.spi_miso_o(spi_miso_o),
		.spi_miso_oe_o(spi_miso_oe_o),
		.rx_data_valid_i(rx_data_valid_i),
		.rx_data_i(rx_data_i),
		.rx_data_ready_o(rx_data_ready_o),
		.tx_data_valid_o(tx_data_valid_o),
		.tx_data_o(tx_data_o),
		.tx_data_ready_i(tx_data_ready_i),
		.rx_flush_i(rx_flush_i),
		.tx_flush_i(tx_flush_i),
		.buffer_threshold_select_i(buffer_threshold_select_i),
		.output_pin_signal_select_i(output_pin_signal_select_i),
		.rx_buffer_count_o(rx_buffer_count_o),
		.tx_buffer_count_o(tx_buffer_count_o),
		.rx_overflow_o(rx_overflow_o),
		.tx_underflow_o(tx_underflow_o),
		.rx_threshold_o(rx_threshold_o),
		.tx_threshold_o(tx_threshold_o),
		.general_output_pin_o(general_output_pin_o)
	);
	rrtf_host_model rrtf_host_model_inst (.spi_csn_o(spi_csn_i), .spi_sclk_o(spi_sclk_i),
		.spi_mosi_o(spi_mosi_i), .spi_miso_i(miso_w));
	// Clock
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// New threshold, settle, compare counts, threshold flags, pins and output enable with the model
	task automatic step();
		int v;
		logic rt, tt;
		buffer_threshold_select_i = 4'(rnd());
		v = buffer_threshold_select_i;
		rt = rxq.size() >= 4 * (v + 1);
		tt = txq.size() >= 61 - 4 * v;
		repeat (4) @(negedge mclk_i);
		check(8'(rx_buffer_count_o), 8'(rxq.size()));
		check(8'(tx_buffer_count_o), 8'(txq.size()));
		check(8'(rx_threshold_o), 8'(rt));
		check(8'(tx_threshold_o), 8'(tt));
		check(8'(general_output_pin_o), {5'h00, 1'b0, tt, rt});
		check(8'(spi_miso_oe_o), 8'h00);
	endtask : step
	// Radio offers one received byte
	task automatic push(input logic [7:0] d);
		rx_data_valid_i = 1'b1;
		rx_data_i = d;
		check(8'(rx_data_ready_o), 8'(rxq.size() < 64));
		if (rxq.size() < 64) rxq.push_back(d);
		@(negedge mclk_i);
		rx_data_valid_i = 1'b0;
		step();
	endtask : push
	// Radio takes one byte to send
	task automatic pull();
		tx_data_ready_i = 1'b1;
		check(8'(tx_data_valid_o), 8'(txq.size() != 0));
		if (txq.size() != 0) check(tx_data_o, txq.pop_front());
		@(negedge mclk_i);
		tx_data_ready_i = 1'b0;
		step();
	endtask : pull
	// Host serial access, read of receive or write of transmit buffer
	task automatic host(input logic rd_n, input logic [7:0] d);
		logic [7:0] st, rd;
		int n;
		n = rd_n ? rxq.size() : txq.size();
		rrtf_host_model_inst.xfer({rd_n, 1'(rnd()), 6'h3f}, d, st, rd);
		check(st, 8'(n > 15 ? 15 : n));
		if (rd_n) check(rd, rxq.pop_front());
		else txq.push_back(d);
		step();
	endtask : host
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	// Reset, then receive and transmit paths in turn
	initial begin
		repeat (5) @(negedge mclk_i);
		srst_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		for (int i = 0; i < 65; i++) push(8'(rnd()));
		check(8'(rx_overflow_o), 8'h01);
		while (rxq.size() > 0) host(1'b1, 8'h00);
		rx_flush_i = 1'b1;
		@(negedge mclk_i);
		rx_flush_i = 1'b0;
		step();
		check(8'(rx_overflow_o), 8'h00);
		$display("Receive path test done");
		for (int i = 0; i < 64; i++) host(1'b0, 8'(rnd()));
		for (int i = 0; i < 65; i++) pull();
		check(8'(tx_underflow_o), 8'h01);
		tx_flush_i = 1'b1;
		@(negedge mclk_i);
		tx_flush_i = 1'b0;
		step();
		check(8'(tx_underflow_o), 8'h00);
		$display("Transmit path test done");
		give_verdict();
	end
	// Watchdog
	initial begin
		#300000;
		fails++;
		give_verdict();
	end
endmodule : testbench
bind rrtf_top rrtf_checker #(.DEPTH(DEPTH)) rrtf_checker_inst (
	.mclk_i(mclk_i),
	.srst_i(srst_i),
	.spi_csn_i(spi_csn_i),
	.rx_data_valid_i(rx_data_valid_i),
	.tx_data_ready_i(tx_data_ready_i),
	.rx_flush_i(rx_flush_i),
	.tx_flush_i(tx_flush_i),
	.buffer_threshold_select_i(buffer_threshold_select_i),
	.output_pin_signal_select_i(output_pin_signal_select_i),
	.rx_data_ready_o(rx_data_ready_o),
	.tx_data_valid_o(tx_data_valid_o),
	.rx_buffer_count_o(rx_buffer_count_o),
	.tx_buffer_count_o(tx_buffer_count_o),
	.rx_overflow_o(rx_overflow_o),
	.tx_underflow_o(tx_underflow_o),
	.rx_threshold_o(rx_threshold_o),
	.tx_threshold_o(tx_threshold_o),
	.general_output_pin_o(general_output_pin_o)
);
`default_nettype wire
